// [swm_dev_model.sv]
// Purpose: behavioural single-wire device facing the master
// Assumes: line sampled at 25 MHz
// Notes: presence, read answers, write sampling and a program flag only
`timescale 1ns/100ps
module swm_dev_model (
    input wire logic i_ref_clk,
    input wire logic i_line,
    input wire logic i_vpp,
    input wire logic i_tx_bit,
    output logic o_pull,
    output logic o_rx_bit,
    output logic o_prog
);
    logic line_q = 1'b1;
    int low_n = 0;
    int since = 100000;
    int pres_t = 100000;
    logic rx_q = 1'b1;
    logic prog_q = 1'b0;
    assign o_rx_bit = rx_q;
    assign o_prog = prog_q;
    // pulls only to answer a reset or to send a zero
    assign o_pull = (pres_t >= 750 && pres_t < 3750) || (!i_tx_bit && since < 375);
    always @(posedge i_ref_clk) begin
        line_q <= i_line;
        low_n <= i_line ? 0 : low_n + 1;
        since <= (line_q && !i_line && !o_pull) ? 0 : since + 1;
        pres_t <= (!line_q && i_line && low_n > 11000) ? 0 : pres_t + 1;
        if (since == 750) rx_q <= i_line;
        if (i_vpp) prog_q <= 1'b1;
    end
endmodule

// [swm_master.sv]
// Purpose: single-wire bus master: reset/presence, bit slots, program pulse, CRC-8
// Assumes: open-drain line with external pull-up; 12 V switch driven by o_vpp_en
// Notes: one operation per i_req; bytes and triplets are built from single slots
`timescale 1ns/100ps
module swm_master (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_req,
    input wire logic [1:0] i_op,
    input wire logic i_wbit,
    input wire logic i_crc_load,
    input wire logic [7:0] i_crc_seed,
    input wire logic i_crc_clr,
    input wire logic i_line,
    output logic o_ready,
    output logic o_done,
    output logic o_rbit,
    output logic o_presence,
    output logic [7:0] o_crc,
    output logic o_line_o,
    output logic o_line_oe,
    output logic o_vpp_en
);
    // ****************************************************************
    // line synchroniser
    // ****************************************************************
    logic line_s1;
    logic line_s2;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            line_s1 <= 1'b1;
            line_s2 <= 1'b1;
        end else begin
            line_s1 <= i_line;
            line_s2 <= line_s1;
        end
    end

    // ****************************************************************
    // slot sequencer
    // ****************************************************************
    swm_pkg::swm_state_t state;
    logic [1:0] op;
    logic wbit;
    logic [swm_pkg::CNT_W-1:0] cnt;
    logic [swm_pkg::CNT_W-1:0] low_len;
    logic [swm_pkg::CNT_W-1:0] high_len;
    logic [swm_pkg::CNT_W-1:0] samp_at;
    logic sample_now;
    logic crc_shift;

    always_comb begin
        low_len = swm_pkg::CNT_W'(swm_pkg::CYC_RSTL);
        high_len = swm_pkg::CNT_W'(swm_pkg::CYC_RSTH);
        samp_at = swm_pkg::CNT_W'(swm_pkg::CYC_PDS);
        case (op)
            swm_pkg::OP_WRITE: begin
                // short low for one, long low for zero
                low_len = wbit ? swm_pkg::CNT_W'(swm_pkg::CYC_LOW1)
                               : swm_pkg::CNT_W'(swm_pkg::CYC_LOW0);
                high_len = swm_pkg::CNT_W'(swm_pkg::CYC_SLOT) - low_len;
                samp_at = '0;
            end
            swm_pkg::OP_READ: begin
                low_len = swm_pkg::CNT_W'(swm_pkg::CYC_LOW1);
                high_len = swm_pkg::CNT_W'(swm_pkg::CYC_SLOT - swm_pkg::CYC_LOW1);
                samp_at = swm_pkg::CNT_W'(swm_pkg::CYC_RDS - swm_pkg::CYC_LOW1);
            end
            default: begin
            end
        endcase
    end

    assign o_ready = (state == swm_pkg::ST_IDLE);
    assign sample_now = (state == swm_pkg::ST_HIGH) && (cnt == samp_at);

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= swm_pkg::ST_IDLE;
            op <= swm_pkg::OP_RESET;
            wbit <= 1'b1;
            cnt <= '0;
        end else begin
            case (state)
                swm_pkg::ST_IDLE: begin
                    cnt <= '0;
                    if (i_req) begin
                        op <= i_op;
                        wbit <= i_wbit;
                        // program pulse on the caller's request alone; no CRC check gates it
                        state <= (i_op == swm_pkg::OP_PROG) ? swm_pkg::ST_PROG
                                                            : swm_pkg::ST_LOW;
                    end
                end
                swm_pkg::ST_LOW: begin
                    if (cnt == low_len - 1'b1) begin
                        cnt <= '0;
                        state <= swm_pkg::ST_HIGH;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                swm_pkg::ST_HIGH: begin
                    if (cnt == high_len - 1'b1) begin
                        cnt <= '0;
                        state <= swm_pkg::ST_REC;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                swm_pkg::ST_REC: begin
                    if (cnt == swm_pkg::CNT_W'(swm_pkg::CYC_REC - 1)) begin
                        cnt <= '0;
                        state <= swm_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                swm_pkg::ST_PROG: begin
                    // delay to program, then pulse, then delay to verify
                    if (cnt == swm_pkg::CNT_W'(swm_pkg::CYC_PP + 2 * swm_pkg::CYC_DP - 1)) begin
                        cnt <= '0;
                        state <= swm_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: state <= swm_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // line and programming drive
    // ****************************************************************
    assign o_line_o = 1'b0;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_line_oe <= 1'b0;
            o_vpp_en <= 1'b0;
        end else begin
            // only the low phase drives; idle always leaves the line released
            o_line_oe <= (state == swm_pkg::ST_IDLE && i_req && i_op != swm_pkg::OP_PROG)
                      || (state == swm_pkg::ST_LOW && cnt != low_len - 1'b1);
            o_vpp_en <= (state == swm_pkg::ST_PROG)
                     && (cnt >= swm_pkg::CNT_W'(swm_pkg::CYC_DP - 1))
                     && (cnt < swm_pkg::CNT_W'(swm_pkg::CYC_DP + swm_pkg::CYC_PP - 1));
        end
    end

    // ****************************************************************
    // results
    // ****************************************************************
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rbit <= 1'b0;
            o_presence <= 1'b0;
            crc_shift <= 1'b0;
        end else begin
            crc_shift <= 1'b0;
            if (sample_now && op == swm_pkg::OP_RESET) begin
                o_presence <= !line_s2;
            end
            if (sample_now && op == swm_pkg::OP_READ) begin
                o_rbit <= line_s2;
                crc_shift <= 1'b1;
            end
            if (sample_now && op == swm_pkg::OP_WRITE) begin
                o_rbit <= wbit;
                crc_shift <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (state == swm_pkg::ST_REC && cnt == swm_pkg::CNT_W'(swm_pkg::CYC_REC - 1))
                   || (state == swm_pkg::ST_PROG
                       && cnt == swm_pkg::CNT_W'(swm_pkg::CYC_PP + 2 * swm_pkg::CYC_DP - 1));
        end
    end

    // ****************************************************************
    // crc-8, bit serial, lsb first
    // ****************************************************************
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_crc <= swm_pkg::CRC_INIT;
        end else if (i_crc_clr) begin
            o_crc <= swm_pkg::CRC_INIT;
        end else if (i_crc_load) begin
            o_crc <= i_crc_seed;
        end else if (crc_shift) begin
            // each slot's bit goes in as it passes, lsb first
            o_crc <= (o_crc >> 1) ^ ((o_crc[0] ^ o_rbit) ? swm_pkg::CRC_POLY_REFL
                                                          : 8'h00);
        end
    end
endmodule

// [swm_master_chk.sv]
// Purpose: timing checker on the master's line and program pins
// Assumes: 25 MHz clock
// Notes: low lengths judged at the release edge
`timescale 1ns/100ps
module swm_master_chk (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_req,
    input wire logic [1:0] i_op,
    input wire logic i_wbit,
    input wire logic o_ready,
    input wire logic o_line_oe,
    input wire logic o_vpp_en
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    logic [1:0] op_q;
    logic wb_q;
    int low_n;
    int vpp_n;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            op_q <= 2'h0;
            wb_q <= 1'b0;
        end else if (o_ready && i_req) begin
            op_q <= i_op;
            wb_q <= i_wbit;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_n <= 0;
            vpp_n <= 0;
        end else begin
            low_n <= o_line_oe ? low_n + 1 : 0;
            vpp_n <= o_vpp_en ? vpp_n + 1 : 0;
        end
    end
    property p_idle_rel; o_ready |-> !o_line_oe && !o_vpp_en; endproperty
    a_idle_rel: assert property (p_idle_rel) else $error("line held in idle");
    property p_slot_start; o_ready && i_req && i_op != 2'h3 |=> o_line_oe; endproperty
    a_slot_start: assert property (p_slot_start) else $error("slot start late");
    property p_rst_len; $fell(o_line_oe) && op_q == 2'h0 |-> low_n inside {[12000:23999]}; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset low length");
    property p_w0_len; $fell(o_line_oe) && op_q == 2'h1 && !wb_q |-> low_n inside {[1500:3000]}; endproperty
    a_w0_len: assert property (p_w0_len) else $error("write zero length");
    property p_short_len;
        $fell(o_line_oe) && (op_q == 2'h2 || (op_q == 2'h1 && wb_q)) |-> low_n inside {[25:374]};
    endproperty
    a_short_len: assert property (p_short_len) else $error("short low length");
    property p_vpp_excl; o_vpp_en |-> !o_line_oe; endproperty
    a_vpp_excl: assert property (p_vpp_excl) else $error("pull during program");
    property p_vpp_len; $fell(o_vpp_en) |-> vpp_n inside {[12000:125000]}; endproperty
    a_vpp_len: assert property (p_vpp_len) else $error("program length");
    property p_vpp_start; o_ready && i_req && i_op == 2'h3 |=> !o_vpp_en ##[100:150] o_vpp_en; endproperty
    a_vpp_start: assert property (p_vpp_start) else $error("program delay");
endmodule

// [swm_master_test.sv]
// Purpose: self-checking bench for the single-wire master
// Assumes: device model answers on the shared line
// Notes: presence first, then slot rows, crc and program cases, then a mid-run reset
`timescale 1ns/100ps
bind swm_master swm_master_chk swm_master_chk_i (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_req(i_req),
    .i_op(i_op),
    .i_wbit(i_wbit),
    .o_ready(o_ready),
    .o_line_oe(o_line_oe),
    .o_vpp_en(o_vpp_en)
);
module swm_master_test;
    logic i_ref_clk = 1'b0, i_arst_n = 1'b0, i_req = 1'b0, i_wbit = 1'b0, tx_bit = 1'b1;
    logic i_crc_load = 1'b0, i_crc_clr = 1'b0, dev_pull, rx_bit, prog_seen;
    logic [1:0] i_op = 2'h0;
    logic [7:0] i_crc_seed = 8'h5a, exp_crc = 8'h00, o_crc;
    logic o_ready, o_done, o_rbit, o_presence, o_line_o, o_line_oe, o_vpp_en;
    int n_mismatch = 0, total_checks = 0;
    // op, written bit, device bit, expected bit; last three form a search triplet
    logic [4:0] rows [7] = '{5'h0f, 5'h0a, 5'h10, 5'h13, 5'h10, 5'h13, 5'h0a};
    wire i_line = !(o_line_oe && !o_line_o) && !dev_pull;
    swm_master swm_master_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_req(i_req),
        .i_op(i_op), .i_wbit(i_wbit), .i_crc_load(i_crc_load), .i_crc_seed(i_crc_seed),
        .i_crc_clr(i_crc_clr), .i_line(i_line), .o_ready(o_ready), .o_done(o_done),
        .o_rbit(o_rbit), .o_presence(o_presence), .o_crc(o_crc), .o_line_o(o_line_o),
        .o_line_oe(o_line_oe), .o_vpp_en(o_vpp_en));
    swm_dev_model swm_dev_model_i (.i_ref_clk(i_ref_clk), .i_line(i_line), .i_vpp(o_vpp_en),
        .i_tx_bit(tx_bit), .o_pull(dev_pull), .o_rx_bit(rx_bit), .o_prog(prog_seen));
    initial forever #20 i_ref_clk = ~i_ref_clk;
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        // x^8+x^5+x^4+1 in shift-right form
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? 8'h8c : 8'h00);
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_op(input logic [1:0] op, input logic wb);
        @(negedge i_ref_clk);
        i_op = op;
        i_wbit = wb;
        i_req = 1'b1;
        @(negedge i_ref_clk);
        i_req = 1'b0;
        while (o_done !== 1'b1) @(negedge i_ref_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        repeat (90000) @(posedge i_ref_clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        @(negedge i_ref_clk);
        check("idle", 8'h08, {3'h0, o_line_o, o_ready, o_line_oe, o_vpp_en, o_done});
        run_op(swm_pkg::OP_RESET, 1'b0);
        check("presence", 8'h01, {7'h00, o_presence});
        i_crc_clr = 1'b1;
        @(negedge i_ref_clk);
        i_crc_clr = 1'b0;
        $display("reset test done");
        for (int i = 0; i < 7; i++) begin
            tx_bit = rows[i][1];
            run_op(rows[i][4:3], rows[i][2]);
            exp_crc = crc_step(exp_crc, rows[i][0]);
            check("slot bit", {7'h00, rows[i][0]}, {7'h00, (rows[i][4] ? o_rbit : rx_bit)});
        end
        check("slot crc", exp_crc, o_crc);
        $display("slot rows done");
        i_crc_load = 1'b1;
        @(negedge i_ref_clk);
        check("crc seed", 8'h5a, o_crc);
        i_crc_clr = 1'b1;
        @(negedge i_ref_clk);
        i_crc_load = 1'b0;
        i_crc_clr = 1'b0;
        check("crc clear", 8'h00, o_crc);
        run_op(swm_pkg::OP_PROG, 1'b0);
        check("program", 8'h03, {6'h00, prog_seen, i_line});
        $display("crc and program test done");
        // reset dropped in the middle of a write-zero slot must release the line at once
        @(negedge i_ref_clk);
        i_op = swm_pkg::OP_WRITE;
        i_wbit = 1'b0;
        i_req = 1'b1;
        @(negedge i_ref_clk);
        i_req = 1'b0;
        repeat (100) @(negedge i_ref_clk);
        i_arst_n = 1'b0;
        @(negedge i_ref_clk);
        check("reset drop", 8'h08, {3'h0, o_line_o, o_ready, o_line_oe, o_vpp_en, o_done});
        i_arst_n = 1'b1;
        tx_bit = 1'b1;
        run_op(swm_pkg::OP_READ, 1'b0);
        check("reset read", 8'h01, {7'h00, o_rbit});
        check("reset crc", crc_step(8'h00, 1'b1), o_crc);
        $display("mid-run reset test done");
        test_done();
    end
endmodule

// [swm_pkg.sv]
// Purpose: constants for the single-wire bus master
// Assumes: 25 MHz reference clock
// Notes: times in ns, counts derived from the clock period
package swm_pkg;
    localparam int CLK_NS = 40;
    localparam int T_RSTL_NS = 480000;
    localparam int T_RSTH_NS = 480000;
    localparam int T_SLOT_NS = 70000;
    localparam int T_LOW1_NS = 6000;
    localparam int T_LOW0_NS = 65000;
    localparam int T_RDS_NS = 13000;
    localparam int T_REC_NS = 5000;
    localparam int T_PDS_NS = 70000;
    localparam int T_PP_NS = 480000;
    localparam int T_DP_NS = 5000;
    localparam int CYC_RSTL = (T_RSTL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_RSTH = (T_RSTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_SLOT = (T_SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_LOW1 = (T_LOW1_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_LOW0 = (T_LOW0_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_RDS = T_RDS_NS / CLK_NS;
    localparam int CYC_REC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_PDS = T_PDS_NS / CLK_NS;
    localparam int CYC_PP = (T_PP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_DP = (T_DP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_PROG = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOW = 3'h1,
        ST_HIGH = 3'h3,
        ST_REC = 3'h2,
        ST_PROG = 3'h6
    } swm_state_t;
endpackage
